// File: core/motion_cmd_pkg.sv
// Constants for the stepper motion command decoder.
// Assumes a single pclk domain and an APB register port.
package motion_cmd_pkg;
    // Command codes
    localparam logic [7:0] CMD_TARGET_POS   = 8'hE0;
    localparam logic [7:0] CMD_TARGET_VEL   = 8'hE3;
    localparam logic [7:0] CMD_HALT_SET_POS = 8'hEC;
    localparam logic [7:0] CMD_HALT_HOLD    = 8'h89;
    localparam logic [7:0] CMD_GO_HOME      = 8'h97;
    localparam logic [7:0] CMD_RESET_TMO    = 8'h8C;
    localparam logic [7:0] CMD_DEENERGIZE   = 8'h86;
    localparam logic [7:0] CMD_ENERGIZE     = 8'h85;
    localparam logic [7:0] CMD_SET_CONFIG   = 8'h13;
    localparam logic [7:0] CMD_REINIT       = 8'h10;
    localparam logic [7:0] CMD_BOOTLOADER   = 8'hFF;

    // Command formats
    typedef enum logic [2:0] {
        FMT_QUICK, FMT_WRITE7, FMT_WRITE32, FMT_BLOCK_READ, FMT_CONFIG, FMT_UNKNOWN
    } cmd_fmt_e;

    // Input state codes
    localparam logic [2:0] IN_NOT_READY  = 3'h0;
    localparam logic [2:0] IN_INVALID    = 3'h1;
    localparam logic [2:0] IN_HALT       = 3'h2;
    localparam logic [2:0] IN_TARGET_POS = 3'h3;
    localparam logic [2:0] IN_TARGET_VEL = 3'h4;

    // Velocity limit, microsteps per 10,000 s
    localparam logic signed [31:0] VEL_LIMIT = 32'sd500000000;

    // Host interface sources
    localparam logic [1:0] SRC_SERIAL = 2'h0;
    localparam logic [1:0] SRC_I2C    = 2'h1;
    localparam logic [1:0] SRC_USB    = 2'h2;

    // Register byte offsets
    localparam logic [11:0] REG_CMD      = 12'h000;
    localparam logic [11:0] REG_DATA     = 12'h004;
    localparam logic [11:0] REG_CTRL     = 12'h008;
    localparam logic [11:0] REG_STATUS   = 12'h00C;
    localparam logic [11:0] REG_POSITION = 12'h010;
    localparam logic [11:0] REG_TARGET   = 12'h014;
    localparam logic [11:0] REG_SCALED   = 12'h018;
    localparam logic [11:0] REG_IRQ_STAT = 12'h01C;
    localparam logic [11:0] REG_IRQ_MASK = 12'h020;
    localparam logic [11:0] REG_WDOG     = 12'h024;

    // REG_CMD fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_SRC_LSB  = 8;
    // REG_CTRL fields
    localparam int CTRL_HOST_MODE = 0;
    localparam int CTRL_WDOG_EN   = 1;
    // REG_STATUS fields
    localparam int ST_DOUBT      = 0;
    localparam int ST_DEENERGIZE = 1;
    localparam int ST_DRV_EN     = 2;
    localparam int ST_HOMING     = 3;
    localparam int ST_HOME_FWD   = 4;
    localparam int ST_TIMEOUT    = 5;
    localparam int ST_BUSY       = 6;
    localparam int ST_INPUT_LSB  = 8;
    localparam int ST_MOTION_LSB = 12;
    // Interrupt bits
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_REJECT   = 1;
    localparam int IRQ_TIMEOUT  = 2;
    localparam int IRQ_HOME     = 3;
    localparam int IRQ_WIDTH    = 4;

    // Motion modes
    localparam logic [1:0] MOT_IDLE = 2'h0;
    localparam logic [1:0] MOT_POS  = 2'h1;
    localparam logic [1:0] MOT_VEL  = 2'h2;

    localparam logic [31:0] WDOG_DEFAULT = 32'h0000_F424;
endpackage : motion_cmd_pkg

// File: core/stepper_motion_command_decoder.sv
// Command decoder for a stepper motor controller, driven over APB.
// Assumes software forwards each host command with its source interface.
//
// Summary of operation
// RULE1: Each command is sorted into quick, 7-bit write, 32-bit write or block read; the code gives config write its own format.
// RULE2: Commands from all interfaces are taken, except USB-only ones from other sources.
// RULE3: The USB-only configuration write uses its own dedicated format.
// RULE4: Command E0 starts a move to the signed target in host mode, else is dropped.
// RULE5: Command E3 sets a target velocity within the limit in host mode, else is dropped.
// RULE6: Command EC halts, loads position, clears doubt, sets halt, zeroes scaled input in host mode.
// RULE7: Command 89 halts, sets doubt, sets halt and zeroes scaled input in host mode.
// RULE8: Command 97 starts homing, data 0 reverse and data 1 forward.
// RULE9: Command 8C restarts the command watchdog when it is enabled.
// RULE10: Command 86 disables the driver, sets doubt, power-down error, red lamp and fault.
// RULE11: Power-up undoes power-down except the doubt flag, which stays set.
// RULE12: Input state codes are 0 to 4 and halt writes code 2.
// RULE13: Command 85 clears the power-down error and re-enables the driver unless the watchdog has timed out.
// RULE14: Commands run in arrival order, one finished before the next is decoded.
`timescale 1ns/1ps
module stepper_motion_command_decoder
    import motion_cmd_pkg::*;
#(
    parameter logic [31:0] WDOG_PERIOD = WDOG_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        home_done,
    output logic             drv_enable,
    output logic             red_led,
    output logic             fault_out,
    output logic             halt_pulse,
    output logic             home_start,
    output logic             home_fwd,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic        wr;
    logic        home_done_s1_q;
    logic        home_done_s2_q;
    assign wr = psel && penable && pwrite;
    logic [31:0]          data_q;
    logic [1:0]           ctrl_q;
    logic [IRQ_WIDTH-1:0] irq_stat_q;
    logic [IRQ_WIDTH-1:0] irq_mask_q;
    logic [31:0]          wdog_cnt_q;
    logic                 wdog_to_q;
    logic signed [31:0]   pos_q;
    logic signed [31:0]   target_q;
    logic signed [31:0]   scaled_q;
    logic [2:0]           input_q;
    logic [1:0]           motion_q;
    logic                 doubt_q;
    logic                 deen_q;
    logic                 homing_q;

    // ----------------------------------------------------------------
    // Command staging
    // ----------------------------------------------------------------
    logic       pend_q;
    logic [7:0] code_q;
    logic [1:0] src_q;
    logic [2:0] busy_q;
    logic       cmd_wr;

    // RULE14 one command at a time
    assign cmd_wr = wr && (paddr == REG_CMD) && pstrb[0] && !pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
            code_q <= 8'h00;
            src_q  <= 2'h0;
        end else if (cmd_wr) begin
            pend_q <= 1'b1;
            code_q <= pwdata[CMD_CODE_LSB +: 8];
            src_q  <= pwdata[CMD_SRC_LSB +: 2];
        end else begin
            pend_q <= 1'b0;
        end
    end

    // RULE1 format sorting
    cmd_fmt_e fmt;
    logic     usb_only;
    always_comb begin
        fmt      = FMT_UNKNOWN;
        usb_only = 1'b0;
        unique case (code_q)
            CMD_HALT_HOLD, CMD_RESET_TMO, CMD_DEENERGIZE, CMD_ENERGIZE: fmt = FMT_QUICK;
            CMD_GO_HOME:                                 fmt = FMT_WRITE7;
            CMD_TARGET_POS, CMD_TARGET_VEL, CMD_HALT_SET_POS: fmt = FMT_WRITE32;
            // RULE3 own format for config write
            CMD_SET_CONFIG: begin
                fmt      = FMT_CONFIG;
                usb_only = 1'b1;
            end
            CMD_REINIT, CMD_BOOTLOADER: begin
                fmt      = FMT_QUICK;
                usb_only = 1'b1;
            end
            default:                                     fmt = FMT_UNKNOWN;
        endcase
    end

    // RULE2 USB-only gate
    logic accept;
    logic host_mode;
    assign accept    = pend_q && !(usb_only && (src_q != SRC_USB)) && (fmt != FMT_UNKNOWN);
    assign host_mode = ctrl_q[CTRL_HOST_MODE];

    logic do_pos;
    logic do_vel;
    logic do_hsp;
    logic do_hold;
    logic do_home;
    logic do_tmo;
    logic do_deen;
    logic do_en;
    assign do_pos  = accept && (code_q == CMD_TARGET_POS) && host_mode;
    assign do_vel  = accept && (code_q == CMD_TARGET_VEL) && host_mode;
    assign do_hsp  = accept && (code_q == CMD_HALT_SET_POS) && host_mode;
    assign do_hold = accept && (code_q == CMD_HALT_HOLD) && host_mode;
    assign do_home = accept && (code_q == CMD_GO_HOME);
    assign do_tmo  = accept && (code_q == CMD_RESET_TMO);
    assign do_deen = accept && (code_q == CMD_DEENERGIZE);
    assign do_en   = accept && (code_q == CMD_ENERGIZE);

    logic signed [31:0] vel_clip;
    always_comb begin
        vel_clip = data_q;
        if ($signed(data_q) > VEL_LIMIT) begin
            vel_clip = VEL_LIMIT;
        end else if ($signed(data_q) < -VEL_LIMIT) begin
            vel_clip = -VEL_LIMIT;
        end
    end

    // ----------------------------------------------------------------
    // Motion state
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q    <= 32'sh0000_0000;
            target_q <= 32'sh0000_0000;
            scaled_q <= 32'sh0000_0000;
            input_q  <= IN_NOT_READY;
            motion_q <= MOT_IDLE;
        end else if (do_pos) begin
            // RULE4 move toward target
            target_q <= data_q;
            scaled_q <= data_q;
            input_q  <= IN_TARGET_POS;
            motion_q <= MOT_POS;
        end else if (do_vel) begin
            // RULE5 clipped velocity target
            target_q <= vel_clip;
            scaled_q <= vel_clip;
            input_q  <= IN_TARGET_VEL;
            motion_q <= MOT_VEL;
        end else if (do_hsp) begin
            // RULE6 halt and load position
            pos_q    <= data_q;
            scaled_q <= 32'sh0000_0000;
            // RULE12 halt code
            input_q  <= IN_HALT;
            motion_q <= MOT_IDLE;
        end else if (do_hold || do_deen) begin
            // RULE7 abrupt halt
            scaled_q <= 32'sh0000_0000;
            input_q  <= do_hold ? IN_HALT : input_q;
            motion_q <= MOT_IDLE;
        end
    end

    // Position doubt flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            doubt_q <= 1'b0;
        end else if (do_hold || do_deen) begin
            // RULE10 doubt on power-down
            doubt_q <= 1'b1;
        end else if (do_hsp) begin
            doubt_q <= 1'b0;
        end
    end

    // Power-down error and driver outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deen_q     <= 1'b0;
            drv_enable <= 1'b1;
            red_led    <= 1'b0;
            fault_out  <= 1'b0;
        end else if (do_deen) begin
            // RULE10 coils off, fault shown
            deen_q     <= 1'b1;
            drv_enable <= 1'b0;
            red_led    <= 1'b1;
            fault_out  <= 1'b1;
        end else if (do_en) begin
            // RULE11 undo power-down
            // RULE13 driver back on
            deen_q     <= 1'b0;
            drv_enable <= !wdog_to_q;
            red_led    <= wdog_to_q;
            fault_out  <= wdog_to_q;
        end else if (wdog_to_q) begin
            drv_enable <= 1'b0;
            red_led    <= 1'b1;
            fault_out  <= 1'b1;
        end
    end

    // RULE8 homing start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            homing_q   <= 1'b0;
            home_start <= 1'b0;
            home_fwd   <= 1'b0;
        end else begin
            home_start <= do_home;
            if (do_home) begin
                homing_q <= 1'b1;
                home_fwd <= data_q[0];
            end else if (home_done_s2_q) begin
                homing_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_pulse <= 1'b0;
        end else begin
            halt_pulse <= do_hsp || do_hold || do_deen;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_done_s1_q <= 1'b0;
            home_done_s2_q <= 1'b0;
        end else begin
            home_done_s1_q <= home_done;
            home_done_s2_q <= home_done_s1_q;
        end
    end

    // RULE9 watchdog restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_q <= WDOG_DEFAULT;
            wdog_to_q  <= 1'b0;
        end else if (!ctrl_q[CTRL_WDOG_EN]) begin
            wdog_cnt_q <= WDOG_PERIOD;
            wdog_to_q  <= 1'b0;
        end else if (do_tmo) begin
            wdog_cnt_q <= WDOG_PERIOD;
            wdog_to_q  <= 1'b0;
        end else if (wdog_cnt_q != 32'h0000_0000) begin
            wdog_cnt_q <= wdog_cnt_q - 32'h0000_0001;
        end else begin
            wdog_to_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 32'h0000_0000;
            ctrl_q <= 2'h0;
        end else begin
            if (wr && (paddr == REG_DATA) && !pend_q) begin
                data_q <= pwdata;
            end
            if (wr && (paddr == REG_CTRL)) begin
                ctrl_q <= pwdata[1:0];
            end
        end
    end

    logic [IRQ_WIDTH-1:0] irq_set;
    logic                 wdog_to_d1_q;
    assign irq_set = {home_done_s2_q && homing_q, wdog_to_q && !wdog_to_d1_q,
                      pend_q && !accept, accept};

    // Sticky events, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q   <= '0;
            irq_mask_q   <= '0;
            wdog_to_d1_q <= 1'b0;
            irq          <= 1'b0;
        end else begin
            wdog_to_d1_q <= wdog_to_q;
            if (wr && (paddr == REG_IRQ_STAT)) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_WIDTH-1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            if (wr && (paddr == REG_IRQ_MASK)) begin
                irq_mask_q <= pwdata[IRQ_WIDTH-1:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    logic [31:0] status;
    always_comb begin
        status                     = 32'h0000_0000;
        status[ST_DOUBT]           = doubt_q;
        status[ST_DEENERGIZE]      = deen_q;
        status[ST_DRV_EN]          = drv_enable;
        status[ST_HOMING]          = homing_q;
        status[ST_HOME_FWD]        = home_fwd;
        status[ST_TIMEOUT]         = wdog_to_q;
        status[ST_BUSY]            = pend_q;
        status[ST_INPUT_LSB +: 3]  = input_q;
        status[ST_MOTION_LSB +: 2] = motion_q;
    end

    logic [31:0] rd_d;
    logic        bad;
    always_comb begin
        rd_d = 32'h0000_0000;
        bad  = 1'b0;
        unique case (paddr)
            REG_CMD:      rd_d = {22'h0, src_q, code_q};
            REG_DATA:     rd_d = data_q;
            REG_CTRL:     rd_d = {30'h0, ctrl_q};
            REG_STATUS:   rd_d = status;
            REG_POSITION: rd_d = pos_q;
            REG_TARGET:   rd_d = target_q;
            REG_SCALED:   rd_d = scaled_q;
            REG_IRQ_STAT: rd_d = {28'h0, irq_stat_q};
            REG_IRQ_MASK: rd_d = {28'h0, irq_mask_q};
            REG_WDOG:     rd_d = wdog_cnt_q;
            default:      bad  = 1'b1;
        endcase
    end

    // Zero-wait answer registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && bad;
            prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

endmodule : stepper_motion_command_decoder

// File: test/motion_cmd_properties.sv
// Concurrent checks on the motion command decoder's ports.
// Assumes one pclk domain, presetn async active low, APB master.
`timescale 1ns/1ps
module motion_cmd_properties
    import motion_cmd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        drv_enable,
    input wire logic        red_led,
    input wire logic        fault_out,
    input wire logic        halt_pulse,
    input wire logic        home_start,
    input wire logic        home_fwd,
    input wire logic        irq
);
    logic       host_q;
    logic       dat0_q;
    logic       wr;
    logic       go;
    logic [7:0] code;

    assign wr   = psel && penable && pready && pwrite;
    assign go   = wr && (paddr == REG_CMD);
    assign code = pwdata[7:0];

    // Host mode and data bit as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_q <= 1'b0;
            dat0_q <= 1'b0;
        end else begin
            if (wr && paddr == REG_CTRL) host_q <= pwdata[CTRL_HOST_MODE];
            if (wr && paddr == REG_DATA) dat0_q <= pwdata[0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------
    // Properties
    // ------------------------------
    property p_deen; go && code == CMD_DEENERGIZE |-> ##[1:2] !drv_enable && red_led && fault_out;
    endproperty
    a_deen: assert property (p_deen) else $error("power-down outputs wrong");
    property p_ener; go && code == CMD_ENERGIZE |-> ##[1:2] drv_enable && !red_led && !fault_out;
    endproperty
    a_ener: assert property (p_ener) else $error("power-up outputs wrong");
    property p_home; go && code == CMD_GO_HOME |-> ##[1:2] home_start && home_fwd == dat0_q;
    endproperty
    a_home: assert property (p_home) else $error("homing start wrong");
    property p_halt_on;
        go && host_q && (code == CMD_HALT_HOLD || code == CMD_HALT_SET_POS) |-> ##[1:2] halt_pulse;
    endproperty
    a_halt_on: assert property (p_halt_on) else $error("halt missing");
    property p_halt_off;
        go && !host_q && (code == CMD_HALT_HOLD || code == CMD_HALT_SET_POS) |=> !halt_pulse [*2];
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("halt outside host mode");
    property p_halt_once; halt_pulse |=> !halt_pulse; endproperty
    a_halt_once: assert property (p_halt_once) else $error("halt pulse too long");
    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup) else $error("no ready in access");
    property p_rdy; pready |=> !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready held");
    property p_unmap; psel && !penable && paddr > REG_WDOG |=> pslverr && pready; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_mapped;
        psel && !penable && paddr <= REG_WDOG && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_mask; wr && paddr == REG_IRQ_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq with mask clear");
endmodule : motion_cmd_properties

// File: test/home_sensor_model.sv
// Home sensor model: reports homing finished some cycles after a start.
// Assumes home_start is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
module home_sensor_model #(
    parameter int DELAY = 6
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic home_start,
    output logic      home_done
);
    int cnt_q;

    // Done level held four cycles, low otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 0;
            home_done <= 1'b0;
        end else begin
            if (home_start) cnt_q <= DELAY + 4;
            else if (cnt_q > 0) cnt_q <= cnt_q - 1;
            home_done <= (cnt_q > 0) && (cnt_q <= 4);
        end
    end
endmodule : home_sensor_model

// File: test/test_stepper_motion_command_decoder.sv
// Self-checking bench for the motion command decoder over APB.
// Assumes the home sensor model and the property checker beside it.
`timescale 1ns/1ps
module test_stepper_motion_command_decoder
    import motion_cmd_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, home_done, e;
    logic        pready, pslverr, drv_enable, red_led, fault_out;
    logic        halt_pulse, home_start, home_fwd, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [3:0]  pstrb;
    int          err_count = 0, n_checks = 0, n_halt = 0, n_home = 0;

    stepper_motion_command_decoder #(.WDOG_PERIOD(32'h14)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .home_done(home_done),
        .drv_enable(drv_enable), .red_led(red_led), .fault_out(fault_out),
        .halt_pulse(halt_pulse), .home_start(home_start), .home_fwd(home_fwd), .irq(irq));
    home_sensor_model sen_u (.pclk(pclk), .presetn(presetn), .home_start(home_start),
        .home_done(home_done));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (halt_pulse === 1'b1) n_halt++;
        if (home_start === 1'b1) n_home++;
    end

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(v & m, x);
    endtask : rdm
    task automatic cmd(input logic [7:0] c, input logic [1:0] s, input logic [31:0] d);
        xfer(1'b1, REG_DATA, d);
        xfer(1'b1, REG_CMD, {22'h0, s, c});
        repeat (3) @(posedge pclk);
    endtask : cmd
    task automatic outs(input logic [31:0] x);
        chk({29'h0, drv_enable, red_led, fault_out}, x);
    endtask : outs

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset;
        rdm(REG_STATUS, 32'h4, 32'h4);
        rdm(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
        xfer(1'b0, 12'h100, 32'h0);
        chk(v, 32'h0);
        chk({31'h0, e}, 32'h1);
        xfer(1'b1, 12'h200, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
    endtask : t_reset
    task automatic t_mode_off;
        xfer(1'b1, REG_IRQ_STAT, 32'hF);
        pstrb <= 4'hE;
        xfer(1'b1, REG_CMD, {24'h0, CMD_HALT_HOLD});
        pstrb <= 4'hF;
        rdm(REG_IRQ_STAT, 32'h3, 32'h0);
        cmd(CMD_TARGET_POS, SRC_SERIAL, 32'h55);
        cmd(CMD_TARGET_VEL, SRC_I2C, 32'h66);
        cmd(CMD_HALT_SET_POS, SRC_USB, 32'h77);
        cmd(CMD_HALT_HOLD, SRC_SERIAL, 32'h0);
        rdm(REG_TARGET, 32'hFFFF_FFFF, 32'h0);
        rdm(REG_POSITION, 32'hFFFF_FFFF, 32'h0);
        chk(n_halt, 32'h0);
        rdm(REG_IRQ_STAT, 32'h3, 32'h1);
    endtask : t_mode_off
    task automatic t_pos_vel;
        xfer(1'b1, REG_CTRL, 32'h1);
        cmd(CMD_TARGET_POS, SRC_SERIAL, 32'hFFFF_FF00);
        rdm(REG_TARGET, 32'hFFFF_FFFF, 32'hFFFF_FF00);
        rdm(REG_STATUS, 32'h3000, 32'h1000);
        cmd(CMD_TARGET_VEL, SRC_USB, 32'h23C3_4600);
        rdm(REG_TARGET, 32'hFFFF_FFFF, 32'h1DCD_6500);
        rdm(REG_STATUS, 32'h3000, 32'h2000);
        cmd(CMD_TARGET_VEL, SRC_I2C, 32'hDC3C_BA00);
        rdm(REG_TARGET, 32'hFFFF_FFFF, 32'hE232_9B00);
    endtask : t_pos_vel
    task automatic t_halts;
        cmd(CMD_TARGET_POS, SRC_SERIAL, 32'h40);
        cmd(CMD_HALT_HOLD, SRC_SERIAL, 32'h0);
        rdm(REG_STATUS, 32'h3701, 32'h0201);
        rdm(REG_SCALED, 32'hFFFF_FFFF, 32'h0);
        chk(n_halt, 32'h1);
        cmd(CMD_HALT_SET_POS, SRC_I2C, 32'h8000_0000);
        rdm(REG_POSITION, 32'hFFFF_FFFF, 32'h8000_0000);
        rdm(REG_STATUS, 32'h3701, 32'h0200);
        chk(n_halt, 32'h2);
    endtask : t_halts
    task automatic t_power;
        cmd(CMD_DEENERGIZE, SRC_USB, 32'h0);
        outs(32'h3);
        rdm(REG_STATUS, 32'h7, 32'h3);
        cmd(CMD_ENERGIZE, SRC_SERIAL, 32'h0);
        outs(32'h4);
        rdm(REG_STATUS, 32'h7, 32'h5);
    endtask : t_power
    task automatic t_home;
        xfer(1'b1, REG_IRQ_STAT, 32'hF);
        cmd(CMD_GO_HOME, SRC_SERIAL, 32'h1);
        chk({n_home[30:0], home_fwd}, {31'h1, 1'b1});
        repeat (20) @(posedge pclk);
        rdm(REG_IRQ_STAT, 32'h8, 32'h8);
        rdm(REG_STATUS, 32'h10, 32'h10);
        cmd(CMD_GO_HOME, SRC_I2C, 32'h0);
        chk({n_home[30:0], home_fwd}, {31'h2, 1'b0});
        repeat (20) @(posedge pclk);
    endtask : t_home
    task automatic t_src;
        logic [7:0] c [4] = '{CMD_SET_CONFIG, CMD_REINIT, CMD_BOOTLOADER, 8'h42};
        xfer(1'b1, REG_IRQ_MASK, 32'h2);
        for (int i = 0; i < 4; i++) begin
            for (int s = 0; s < 3; s++) begin
                xfer(1'b1, REG_IRQ_STAT, 32'hF);
                cmd(c[i], s[1:0], 32'h0);
                rdm(REG_IRQ_STAT, 32'h3, (s == 2 && i < 3) ? 32'h1 : 32'h2);
                chk({31'h0, irq}, (s == 2 && i < 3) ? 32'h0 : 32'h1);
            end
        end
        xfer(1'b1, REG_IRQ_STAT, 32'hF);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, REG_IRQ_MASK, 32'h0);
    endtask : t_src
    task automatic t_wdog;
        xfer(1'b1, REG_CTRL, 32'h3);
        repeat (4) begin
            repeat (4) @(posedge pclk);
            cmd(CMD_RESET_TMO, SRC_SERIAL, 32'h0);
        end
        rdm(REG_STATUS, 32'h20, 32'h0);
        repeat (40) @(posedge pclk);
        rdm(REG_STATUS, 32'h20, 32'h20);
        chk({31'h0, drv_enable}, 32'h0);
        xfer(1'b1, REG_CTRL, 32'h1);
        cmd(CMD_ENERGIZE, SRC_I2C, 32'h0);
        chk({31'h0, drv_enable}, 32'h1);
    endtask : t_wdog

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        pstrb   = 4'hF;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_mode_off;
        t_pos_vel;
        t_halts;
        t_power;
        t_home;
        t_src;
        t_wdog;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        give_verdict;
    end
endmodule : test_stepper_motion_command_decoder

bind stepper_motion_command_decoder motion_cmd_properties chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .drv_enable(drv_enable), .red_led(red_led), .fault_out(fault_out),
    .halt_pulse(halt_pulse), .home_start(home_start), .home_fwd(home_fwd), .irq(irq));
